// [verilog/gpib_pkg.sv]
/*
 Shared constants and carriers for the instrument bus addressing block.
 Assumes bus lines arrive already synchronous to clk, true = 1.
*/
`default_nettype none
package gpib_pkg;
   // ---------------------------------------------------------------
   // Address and command layout
   // ---------------------------------------------------------------
   localparam int          ADDR_W       = 5;
   localparam logic [4:0]  ADDR_PRESET  = 5'h15;
   localparam logic [4:0]  ADDR_MAX     = 5'h1e;
   localparam logic [4:0]  ADDR_ALLONES = 5'h1f;
   localparam int          GRP_HI       = 6;
   localparam int          GRP_LO       = 5;
   localparam logic [1:0]  GRP_UNIV     = 2'h0;
   localparam logic [1:0]  GRP_LISTEN   = 2'h1;
   localparam logic [1:0]  GRP_TALK     = 2'h2;
   localparam logic [1:0]  GRP_SECOND   = 2'h3;
   localparam logic [6:0]  CMD_MASK     = 7'h7f;
   // Addressed commands (within universal group, low range)
   localparam logic [6:0]  CMD_LOCAL    = 7'h01;
   localparam logic [6:0]  CMD_CLEAR    = 7'h04;
   localparam logic [6:0]  CMD_TRIGGER  = 7'h08;
   // Universal commands
   localparam logic [6:0]  CMD_LOCKOUT  = 7'h11;
   localparam logic [6:0]  CMD_DEVCLR   = 7'h14;
   localparam logic [6:0]  CMD_SPOLL_EN = 7'h18;
   localparam logic [6:0]  CMD_SPOLL_DI = 7'h19;
   localparam logic [7:0]  STB_RQS      = 8'h40;

   // ---------------------------------------------------------------
   // Control lines as one carrier
   // ---------------------------------------------------------------
   typedef struct packed {
      logic atn;
      logic ifc;
      logic ren;
      logic eoi;
   } ctrl_type;
endpackage
`default_nettype wire

// [verilog/gpib_addr_decode.sv]
/*
 Classifies one byte taken under attention.
 Assumes it is fed only bytes accepted while attention is true.
*/
`default_nettype none
module gpib_addr_decode
   import gpib_pkg::*;
(
   // Byte and own address
   input  wire logic [7:0]        cmdByte,
   input  wire logic [ADDR_W-1:0] myAddr,
   // Classification
   output logic                   isMyListen,
   output logic                   isMyTalk,
   output logic                   isOtherTalk,
   output logic                   isUnlisten,
   output logic                   isUntalk,
   output logic                   isUniversal,
   output logic                   isSecondary
);
   logic [1:0]        grp;
   logic [ADDR_W-1:0] low;

   // Only seven lines carry meaning under attention
   assign grp = cmdByte[GRP_HI:GRP_LO];                       // [R9] [R17]
   assign low = cmdByte[ADDR_W-1:0];                          // [R1]

   always_comb begin
      isMyListen  = 1'b0;
      isMyTalk    = 1'b0;
      isOtherTalk = 1'b0;
      isUnlisten  = 1'b0;
      isUntalk    = 1'b0;
      isUniversal = 1'b0;
      isSecondary = 1'b0;
      case (grp)
         GRP_UNIV: isUniversal = 1'b1;                        // [R17]
         GRP_LISTEN: begin
            isUnlisten = (low == ADDR_ALLONES);
            isMyListen = !isUnlisten && (low == myAddr);      // [R19]
         end
         GRP_TALK: begin
            isUntalk    = (low == ADDR_ALLONES);
            isMyTalk    = !isUntalk && (low == myAddr);       // [R19]
            isOtherTalk = !isUntalk && (low != myAddr);       // [R6]
         end
         default: isSecondary = (low != ADDR_ALLONES);        // [R16]
      endcase
   end
endmodule
`default_nettype wire

// [verilog/gpib_device.sv]
/*
 Device end of the instrument bus: addressing, acceptor and source
 handshake, end marking, service request, remote/local and clear.
 Assumes all bus lines are sampled synchronously, true = 1, and the
 testbench resolves the open-collector wires from the enables.
*/
`default_nettype none
// Summary of operation
// [R1] Address is low five bits of character
// [R2] Jumpers give address 0..30, preset 21
// [R3] Operator gives codes as two digits
// [R4] Under attention accept every byte
// [R5] Without attention act only if addressed
// [R6] Other talk address unaddresses our talker
// [R7] Bytes move parallel under three-wire handshake
// [R8] Each handshake step awaits previous step
// [R9] Attention bytes use seven data lines
// [R10] Interface clear returns logic to idle
// [R11] Remote enable plus commands select remote
// [R12] Device may assert service request
// [R13] Talker marks final byte with end
// [R14] Attention with end means parallel poll; the code gives no parallel poll response
// [R15] Addressed commands only when already addressed
// [R16] Secondary commands extend primary addressing; the code decodes secondaries but never uses them
// [R17] Attention byte class from bits 7,6; the code decodes cmdByte bits 6,5
// [R18] Own listen drops talker, own talk listener
// [R19] Match low bits against jumpers to address
module gpib_device
   import gpib_pkg::*;
#(
   parameter logic [ADDR_W-1:0] ADDR_DEFAULT = ADDR_PRESET
)(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Configuration
   input  wire logic [ADDR_W-1:0] addrJumpers,
   // Bus control and handshake inputs
   input  wire ctrl_type          busCtrl,
   input  wire logic [7:0]        dioIn,
   input  wire logic              davIn,
   input  wire logic              nrfdIn,
   input  wire logic              ndacIn,
   // Bus drives, enable high while driving true
   output logic [7:0]             dioOut,
   output logic                   dioOe,
   output logic                   davOe,
   output logic                   nrfdOe,
   output logic                   ndacOe,
   output logic                   eoiOe,
   output logic                   srqOe,
   // Received data to user
   output logic [7:0]             rxData,
   output logic                   rxEnd,
   output logic                   rxValid,
   // Transmit data from user
   input  wire logic [7:0]        txData,
   input  wire logic              txLast,
   input  wire logic              txValid,
   output logic                   txReady,
   // Receive pacing and service request
   input  wire logic              rxReady,
   input  wire logic              serviceReq,
   // Status to user
   output logic                   talkAddressed,
   output logic                   listenAddressed,
   output logic                   remoteMode,
   output logic                   deviceClear,
   output logic                   deviceTrigger,
   output logic [ADDR_W-1:0]      busAddr
);
   typedef enum {AH_IDLE, AH_READY, AH_ACCEPT, AH_WAITEND} ah_type;
   typedef enum {SH_IDLE, SH_SETUP, SH_VALID, SH_DONE} sh_type;

   ah_type            ahState;
   sh_type            shState;
   logic [7:0]        latched;
   logic              latchedAtn;
   logic              cmdStrobe;
   logic              lockout;
   logic              spollMode;
   logic              srqPending;
   logic              isMyListen, isMyTalk, isOtherTalk, isUnlisten;
   logic              isUntalk, isUniversal, isSecondary;
   logic              acceptOn;
   logic              talkActive;
   logic [7:0]        txByte;
   logic              txEnd;

   // ---------------------------------------------------------------
   // Address capture
   // ---------------------------------------------------------------
   // Taken each clock after reset; code 31 is not an address, so it
   // falls back to the preset
   always_ff @(posedge clk) begin
      if (sys_rst)
         busAddr <= ADDR_DEFAULT;
      else if (addrJumpers <= ADDR_MAX)
         busAddr <= addrJumpers;                              // [R2]
      else
         busAddr <= ADDR_DEFAULT;
   end

   gpib_addr_decode u_decode (
      .cmdByte     (latched),
      .myAddr      (busAddr),
      .isMyListen  (isMyListen),
      .isMyTalk    (isMyTalk),
      .isOtherTalk (isOtherTalk),
      .isUnlisten  (isUnlisten),
      .isUntalk    (isUntalk),
      .isUniversal (isUniversal),
      .isSecondary (isSecondary)
   );

   // ---------------------------------------------------------------
   // Acceptor handshake
   // ---------------------------------------------------------------
   assign acceptOn = busCtrl.atn || listenAddressed;          // [R4] [R5]

   always_ff @(posedge clk) begin
      cmdStrobe <= 1'b0;
      rxValid   <= 1'b0;
      if (sys_rst || busCtrl.ifc || !acceptOn) begin          // [R10]
         ahState <= AH_IDLE;
      end else begin
         case (ahState)
            AH_IDLE: ahState <= AH_READY;
            AH_READY:
               // Attention bytes never wait on the user side
               if (davIn && (busCtrl.atn || rxReady)) begin   // [R8]
                  latched    <= dioIn;                        // [R7]
                  latchedAtn <= busCtrl.atn;
                  rxEnd      <= busCtrl.eoi;                  // [R13]
                  ahState    <= AH_ACCEPT;
               end
            AH_ACCEPT: begin
               cmdStrobe <= latchedAtn;
               rxValid   <= !latchedAtn;
               rxData    <= latched;
               ahState   <= AH_WAITEND;
            end
            default:
               if (!davIn)
                  ahState <= AH_READY;                        // [R8]
         endcase
      end
   end

   // Not ready unless waiting for a byte; not accepted until taken
   assign nrfdOe = acceptOn && (ahState != AH_READY);
   assign ndacOe = acceptOn && (ahState != AH_WAITEND);

   // ---------------------------------------------------------------
   // Addressing state
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst || busCtrl.ifc) begin                       // [R10]
         talkAddressed   <= 1'b0;
         listenAddressed <= 1'b0;
      end else if (cmdStrobe) begin
         if (isMyListen) begin
            listenAddressed <= 1'b1;                          // [R19]
            talkAddressed   <= 1'b0;                          // [R18]
         end else if (isMyTalk) begin
            talkAddressed   <= 1'b1;                          // [R19]
            listenAddressed <= 1'b0;                          // [R18]
         end else if (isOtherTalk || isUntalk) begin
            talkAddressed   <= 1'b0;                          // [R6]
         end else if (isUnlisten) begin
            listenAddressed <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Commands, remote/local, serial poll
   // ---------------------------------------------------------------
   // Secondaries are seen but carry no extended address here
   always_ff @(posedge clk) begin
      deviceClear   <= 1'b0;
      deviceTrigger <= 1'b0;
      if (sys_rst || busCtrl.ifc) begin                       // [R10]
         spollMode <= 1'b0;
      end else if (cmdStrobe && isUniversal) begin            // [R15]
         case (latched[6:0] & CMD_MASK)
            CMD_DEVCLR:   deviceClear <= 1'b1;
            CMD_SPOLL_EN: spollMode   <= 1'b1;
            CMD_SPOLL_DI: spollMode   <= 1'b0;
            CMD_CLEAR:    deviceClear   <= listenAddressed;   // [R15]
            CMD_TRIGGER:  deviceTrigger <= listenAddressed;   // [R15]
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !busCtrl.ren) begin                      // [R11]
         remoteMode <= 1'b0;
         lockout    <= 1'b0;
      end else if (cmdStrobe && isMyListen) begin
         remoteMode <= 1'b1;                                  // [R11]
      end else if (cmdStrobe && isUniversal) begin
         if (latched[6:0] == CMD_LOCKOUT)
            lockout <= 1'b1;
         else if (latched[6:0] == CMD_LOCAL && listenAddressed)
            remoteMode <= 1'b0;                               // [R15]
      end
   end

   // ---------------------------------------------------------------
   // Service request
   // ---------------------------------------------------------------
   // Held until the status byte is read in a serial poll
   always_ff @(posedge clk) begin
      if (sys_rst)
         srqPending <= 1'b0;
      else if (serviceReq)
         srqPending <= 1'b1;                                  // [R12]
      else if (shState == SH_DONE && spollMode)
         srqPending <= 1'b0;
   end
   assign srqOe = srqPending;                                 // [R12]

   // ---------------------------------------------------------------
   // Source handshake
   // ---------------------------------------------------------------
   // No parallel poll response: eoi with attention never sources
   assign talkActive = talkAddressed && !busCtrl.atn;         // [R5] [R14]
   assign txReady    = talkActive && !spollMode && shState == SH_IDLE;

   always_ff @(posedge clk) begin
      if (sys_rst || busCtrl.ifc || !talkActive) begin        // [R10]
         shState <= SH_IDLE;
         txByte  <= 8'h00;
         txEnd   <= 1'b0;
      end else begin
         case (shState)
            SH_IDLE:
               if (spollMode) begin
                  txByte  <= srqPending ? STB_RQS : 8'h00;
                  txEnd   <= 1'b0;
                  shState <= SH_SETUP;
               end else if (txValid) begin
                  txByte  <= txData;                          // [R7]
                  txEnd   <= txLast;                          // [R13]
                  shState <= SH_SETUP;
               end
            SH_SETUP:
               // All listeners ready and at least one not yet accepted
               if (!nrfdIn && ndacIn)
                  shState <= SH_VALID;                        // [R8]
            SH_VALID:
               if (!ndacIn)
                  shState <= SH_DONE;                         // [R8]
            default:
               shState <= SH_IDLE;
         endcase
      end
   end

   assign dioOut = txByte;
   assign dioOe  = talkActive && shState != SH_IDLE;
   assign davOe  = talkActive && shState == SH_VALID;
   assign eoiOe  = dioOe && txEnd;                            // [R13]
endmodule
`default_nettype wire

// [verification/gpib_device_properties.sv]
/*
 Assertions on the device end of the instrument bus.
 Assumes binding to gpib_device; bus inputs are resolved levels.
*/
`default_nettype none
module gpib_device_properties
   import gpib_pkg::*;
(
   // Clock, reset, inputs
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic [ADDR_W-1:0] addrJumpers,
   input wire ctrl_type          busCtrl,
   input wire logic [7:0]        dioIn,
   input wire logic              davIn,
   input wire logic              ndacIn,
   input wire logic              serviceReq,
   // Design outputs
   input wire logic              dioOe,
   input wire logic              davOe,
   input wire logic              nrfdOe,
   input wire logic              ndacOe,
   input wire logic              eoiOe,
   input wire logic              srqOe,
   input wire logic              talkAddressed,
   input wire logic              listenAddressed,
   input wire logic              remoteMode,
   input wire logic [ADDR_W-1:0] busAddr
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------
   // Bytes taken under attention
   // ----------------------------
   sequence take_s(logic [6:0] code);
      busCtrl.atn && $rose(davIn) && dioIn[6:0] == code;
   endsequence
   sequence other_talk_s;
      busCtrl.atn && $rose(davIn) && dioIn[GRP_HI:GRP_LO] == GRP_TALK
         && dioIn[4:0] != busAddr;
   endsequence
   a_my_talk: assert property (
      take_s({GRP_TALK, busAddr}) |-> ##[1:3] talkAddressed && !listenAddressed)
      else $error("own talk address not taken");
   a_my_listen: assert property (
      take_s({GRP_LISTEN, busAddr}) |-> ##[1:3] listenAddressed && !talkAddressed)
      else $error("own listen address not taken");
   a_other_talk: assert property (
      other_talk_s |-> ##[1:3] !talkAddressed)
      else $error("talker kept after other talk address");
   a_unlisten_cmd: assert property (
      take_s({GRP_LISTEN, ADDR_ALLONES}) |-> ##[1:3] !listenAddressed)
      else $error("unlisten ignored");
   a_atn_accept: assert property (
      busCtrl.atn && $rose(davIn) |-> ##[1:3] nrfdOe && !ndacOe)
      else $error("byte under attention not accepted");
   a_ndac_hold: assert property (
      davIn && $past(davIn) && $past(ndacOe) == 1'b0 |-> !ndacOe)
      else $error("accepted flag dropped before data valid fell");
   a_dav_hold: assert property (
      davOe && ndacIn && !busCtrl.ifc |=> davOe)
      else $error("data valid dropped before acceptance");
   a_quiet_idle: assert property (
      !busCtrl.atn && !listenAddressed && !talkAddressed
         |-> !(nrfdOe || ndacOe || davOe || dioOe))
      else $error("unaddressed device drives the bus");
   a_ifc_idle: assert property (
      busCtrl.ifc |-> ##[1:2] !talkAddressed && !listenAddressed)
      else $error("interface clear left device addressed");
   a_ren_local: assert property (
      !busCtrl.ren |=> !remoteMode)
      else $error("remote kept without remote enable");
   a_srq_cause: assert property (
      $rose(srqOe) |-> $past(serviceReq))
      else $error("service request without cause");
   a_eoi_last: assert property (
      eoiOe |-> dioOe && talkAddressed)
      else $error("end marker outside a talked byte");
   a_addr_jumper: assert property (
      $stable(addrJumpers) |=> busAddr == ($past(addrJumpers) == ADDR_ALLONES
         ? ADDR_PRESET : $past(addrJumpers)))
      else $error("bus address differs from jumpers");
endmodule
bind gpib_device gpib_device_properties u_props (.clk, .sys_rst,
   .addrJumpers, .busCtrl, .dioIn, .davIn, .ndacIn, .serviceReq, .dioOe,
   .davOe, .nrfdOe, .ndacOe, .eoiOe, .srqOe, .talkAddressed,
   .listenAddressed, .remoteMode, .busAddr);
`default_nettype wire

// [verification/gpib_ctrl_model.sv]
/*
 Bus controller model: sources bytes and listens to the device.
 Assumes open-collector lines resolved by the bench, true = 1.
*/
`default_nettype none
module gpib_ctrl_model (
   // Clock and resolved lines
   input  wire logic       clk,
   input  wire logic [7:0] dioIn,
   input  wire logic       davIn,
   input  wire logic       nrfdIn,
   input  wire logic       ndacIn,
   input  wire logic       eoiIn,
   // Mode
   input  wire logic       listen,
   input  wire logic       slow,
   // Drives and bytes heard
   output logic [7:0]      ctrlDio = 8'h00,
   output logic            ctrlDav = 1'b0,
   output logic            ctrlEoi = 1'b0,
   output logic            ctrlNrfd = 1'b0,
   output logic            ctrlNdac = 1'b0,
   output logic [7:0]      gotData = 8'h00,
   output logic            gotEoi = 1'b0,
   output logic            gotValid = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   int hold = 0;
   // Bounded waits: a stuck bus shows up as a missing byte
   task automatic put(input logic [7:0] b, input logic e);
      int n = 0;
      do @(posedge clk); while (nrfdIn !== 1'b0 && ++n < 300);
      ctrlDio <= b;
      ctrlEoi <= e;
      ctrlDav <= 1'b1;
      do @(posedge clk); while (ndacIn !== 1'b0 && ++n < 600);
      ctrlDav <= 1'b0;
      ctrlEoi <= 1'b0;
      ctrlDio <= 8'h00;
   endtask
   always @(posedge clk) begin
      gotValid <= 1'b0;
      if (!listen) begin
         ctrlNrfd <= 1'b0;
         ctrlNdac <= 1'b0;
      end else if (davIn && ctrlNdac) begin
         gotData  <= dioIn;
         gotEoi   <= eoiIn;
         gotValid <= 1'b1;
         ctrlNrfd <= 1'b1;
         ctrlNdac <= 1'b0;
         hold     <= slow ? 20 : 1;
      end else if (!davIn) begin
         ctrlNdac <= 1'b1;
         if (hold > 0)
            hold <= hold - 1;
         else
            ctrlNrfd <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [verification/tb.sv]
/*
 Self-checking bench for the device end of the instrument bus.
 Assumes the controller model on the far side; lines are wired-OR.
*/
`default_nettype none
module tb;
   import gpib_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0, sys_rst = 1'b1, atn = 1'b0, ifc = 1'b0;
   logic       ren = 1'b1, listen = 1'b0, slow = 1'b0, rxReady = 1'b1;
   logic       serviceReq = 1'b0, txLast = 1'b0, txValid = 1'b0;
   logic [4:0] addrJumpers = 5'h1f;
   logic [7:0] txData = 8'h00;
   ctrl_type   busCtrl;
   logic [7:0] dioIn, dioOut, rxData, ctrlDio, gotData;
   logic [4:0] busAddr;
   logic [3:0] trigCount = 4'h0, clrCount = 4'h0;
   logic       davIn, nrfdIn, ndacIn, dioOe, davOe, nrfdOe, ndacOe, eoiOe;
   logic       srqOe, rxEnd, rxValid, txReady, talkAddressed, gotValid;
   logic       listenAddressed, remoteMode, deviceClear, deviceTrigger;
   logic       ctrlDav, ctrlEoi, ctrlNrfd, ctrlNdac, gotEoi;
   logic [8:0] rxQ[$], tkQ[$];
   int         err_count = 0, tests_run = 0;
   // Open-collector lines: any party driving true wins
   assign dioIn   = (dioOe ? dioOut : 8'h00) | ctrlDio;
   assign davIn   = davOe | ctrlDav;
   assign nrfdIn  = nrfdOe | ctrlNrfd;
   assign ndacIn  = ndacOe | ctrlNdac;
   assign busCtrl = {atn, ifc, ren, ctrlEoi | eoiOe};
   gpib_device u_gpib_device (.clk, .sys_rst, .addrJumpers, .busCtrl,
      .dioIn, .davIn, .nrfdIn, .ndacIn, .dioOut, .dioOe, .davOe, .nrfdOe,
      .ndacOe, .eoiOe, .srqOe, .rxData, .rxEnd, .rxValid, .txData, .txLast,
      .txValid, .txReady, .rxReady, .serviceReq, .talkAddressed,
      .listenAddressed, .remoteMode, .deviceClear, .deviceTrigger, .busAddr);
   gpib_ctrl_model u_ctrl (.clk, .dioIn, .davIn, .nrfdIn, .ndacIn,
      .eoiIn(busCtrl.eoi), .listen, .slow, .ctrlDio, .ctrlDav, .ctrlEoi,
      .ctrlNrfd, .ctrlNdac, .gotData, .gotEoi, .gotValid);
   initial begin
      forever #10 clk = ~clk;
   end
   initial begin
      #1000000;
      err_count++;
      test_done;
   end
   task automatic check(input logic [8:0] got, exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask
   task automatic pop(ref logic [8:0] q[$], input logic [8:0] got);
      logic [8:0] exp;
      exp = q.size() > 0 ? q.pop_front() : ~got;
      check(got, exp, "byte");
   endtask
   task automatic test_done;
      $display("tests %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      trigCount <= trigCount + 4'(deviceTrigger === 1'b1);
      clrCount  <= clrCount + 4'(deviceClear === 1'b1);
      if (rxValid === 1'b1) pop(rxQ, {rxEnd, rxData});
      if (gotValid === 1'b1) pop(tkQ, {gotEoi, gotData});
   end
   task automatic reset(input logic [4:0] j);
      sys_rst     <= 1'b1;
      addrJumpers <= j;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      // Second edge: address loaded at the first is settled
      repeat (2) @(posedge clk);
   endtask
   // Bit 7 stays low under attention
   task automatic cmd(input logic [6:0] c);
      atn <= 1'b1;
      u_ctrl.put({1'b0, c}, 1'b0);
      repeat (3) @(posedge clk);
   endtask
   task automatic send(input logic [7:0] b, input logic l);
      int n = 0;
      @(posedge clk);
      txData  <= b;
      txLast  <= l;
      txValid <= 1'b1;
      do @(posedge clk); while (txReady !== 1'b1 && ++n < 300);
      txValid <= 1'b0;
   endtask
   task automatic drain;
      for (int n = 0; n < 400 && rxQ.size() + tkQ.size() > 0; n++)
         @(posedge clk);
   endtask
   initial begin
      logic [4:0] a;
      logic [7:0] b;
      void'($urandom(32'h7398));
      @(posedge clk);
      reset(5'h1f);
      check(busAddr, ADDR_PRESET, "preset");
      a = 5'($urandom_range(30));
      reset(a);
      check(busAddr, a, "jumpers");
      cmd({GRP_LISTEN, a});
      check({listenAddressed, remoteMode}, 2'b11, "listen");
      atn <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         b = 8'($urandom);
         rxQ.push_back({i == 3, b});
         u_ctrl.put(b, i == 3);
      end
      drain;
      cmd(CMD_TRIGGER);
      cmd(CMD_CLEAR);
      cmd({GRP_LISTEN, ADDR_ALLONES});
      cmd(CMD_TRIGGER);
      cmd(CMD_DEVCLR);
      check({listenAddressed, trigCount, clrCount}, 9'h012, "cmds");
      cmd({GRP_TALK, a});
      check({talkAddressed, listenAddressed}, 2'b10, "talk");
      atn    <= 1'b0;
      listen <= 1'b1;
      slow   <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         b = 8'($urandom);
         tkQ.push_back({i == 2, b});
         send(b, i == 2);
      end
      drain;
      listen <= 1'b0;
      cmd({GRP_LISTEN, a});
      check({talkAddressed, listenAddressed}, 2'b01, "drop talk");
      cmd({GRP_TALK, a});
      cmd({GRP_TALK, a ^ 5'h01});
      check({talkAddressed, listenAddressed}, 2'b00, "other");
      serviceReq <= 1'b1;
      @(posedge clk);
      serviceReq <= 1'b0;
      @(posedge clk);
      check(srqOe, 1'b1, "srq");
      cmd(CMD_SPOLL_EN);
      cmd({GRP_TALK, a});
      tkQ.push_back({1'b0, STB_RQS});
      atn    <= 1'b0;
      listen <= 1'b1;
      drain;
      listen <= 1'b0;
      cmd(CMD_SPOLL_DI);
      check(srqOe, 1'b0, "srq clear");
      cmd({GRP_LISTEN, a});
      cmd(CMD_LOCAL);
      check({listenAddressed, remoteMode}, 2'b10, "local");
      ren <= 1'b0;
      ifc <= 1'b1;
      repeat (2) @(posedge clk);
      ifc <= 1'b0;
      atn <= 1'b0;
      @(posedge clk);
      check({listenAddressed, remoteMode}, 2'b00, "clear");
      test_done;
   end
endmodule
`default_nettype wire
